// ---- hw/irq_ctrl_pkg.sv ----
// Constants, field layout and types of the core interrupt control block
//
// Contract
// [R1] Global enable at bit 7 lets every unmasked source request the core, and blocks all when 0.
// [R2] Peripheral-group enable at bit 6 passes peripheral requests on, and blocks them when 0.
// [R3] Timer-overflow enable at bit 5 gates the timer-overflow flag onto the request.
// [R4] External-pin enable at bit 4 gates the external-pin flag onto the request.
// [R5] Port-change enable at bit 3 gates the port-change flag onto the request.
// [R6] Timer-overflow flag at bit 2 sets when the 8-bit timer rolls over and holds until cleared.
// [R7] External-pin flag at bit 1 sets on the pin event and holds until software clears it.
// [R8] Port-change flag at bit 0 sets when a monitored pin changes and holds until cleared.
// [R9] A port change counts only on pins whose per-pin change enable is set.
// [R10] Reset leaves the timer count alone, so software loads the timer before clearing its flag.
// [R11] Every flag is set by its event whatever the enable bits hold.
// [R12] On acceptance with global enable set: flush fetch, clear global enable, push PC, load vector.
// [R13] The return-from-interrupt instruction pops the saved address and sets global enable again.
// [R14] Vector execution begins 3 instruction cycles after a sampled event (3 to 4 if asynchronous).
// [R15] Request is global enable AND (any enabled flag pair OR peripheral enable AND peripheral request).
package irq_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the bus
   localparam int         ADDR_W      = 5;
   localparam logic [4:0] OFF_CTRL    = 5'h00;
   localparam logic [4:0] OFF_PIN_EN  = 5'h04;
   localparam logic [4:0] OFF_STATUS  = 5'h08;
   localparam logic [4:0] OFF_MASK    = 5'h0C;
   localparam logic [4:0] OFF_STATE   = 5'h10;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int BIT_GLOBAL_EN  = 7;
   localparam int BIT_PERIPH_EN  = 6;
   localparam int BIT_TIMER_EN   = 5;
   localparam int BIT_PIN_EN     = 4;
   localparam int BIT_PORT_EN    = 3;
   localparam int BIT_TIMER_FLAG = 2;
   localparam int BIT_PIN_FLAG   = 1;
   localparam int BIT_PORT_FLAG  = 0;

   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] PIN_EN_RESET = 8'h00;

   // Event status / mask layout
   localparam int         STAT_W       = 2;
   localparam int         ST_TAKEN     = 0;
   localparam int         ST_RETURN    = 1;
   localparam logic [1:0] STAT_RESET   = 2'h0;
   localparam logic [1:0] MASK_RESET   = 2'h0;

   // State register layout
   localparam int ST_REQ    = 0;
   localparam int ST_PERIPH = 1;
   localparam int ST_BUSY   = 2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Timer rollover and sequencing
   localparam logic [7:0]  TIMER_MAX       = 8'hFF;
   localparam logic [7:0]  TIMER_ZERO      = 8'h00;
   localparam logic [1:0]  IRQ_LATENCY_TCY = 2'h3;
   localparam logic [1:0]  LAT_LAST        = IRQ_LATENCY_TCY - 2'h1;
   localparam logic [1:0]  CNT_ZERO        = 2'h0;
   localparam logic [1:0]  CNT_ONE         = 2'h1;
   localparam int          VECTOR_W        = 13;
   localparam logic [12:0] IRQ_VECTOR      = 13'h0004;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_WAIT = 2'b10
   } seq_state_e;

   function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
      addr_hit = (addr == off);
   endfunction : addr_hit

endpackage : irq_ctrl_pkg

// ---- hw/irq_link_if.sv ----
// Internal carrier between control, event capture and vector sequencer
interface irq_link_if;
   import irq_ctrl_pkg::*;
   logic                timer_evt;
   logic                ext_evt;
   logic                port_evt;
   logic                req;
   logic                tick;
   logic                ret;
   logic                accept;
   logic                push;
   logic                load;
   logic                pop;
   logic                busy;
   logic [VECTOR_W-1:0] vector;

   modport capture (output timer_evt, ext_evt, port_evt);
   modport seq     (input req, tick, ret, output accept, push, load, pop, busy, vector);
   modport ctrl    (input timer_evt, ext_evt, port_evt, accept, push, load, pop, busy, vector,
                    output req, tick, ret);
endinterface : irq_link_if

// ---- hw/event_capture.sv ----
// Edge and change detection for the three core interrupt sources
module event_capture
   import irq_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] eight_bit_timer_count,
   input  wire logic       external_irq_pin,
   input  wire logic       ext_edge_rising,
   input  wire logic [7:0] monitored_port,
   input  wire logic [7:0] per_pin_change_enables,
   irq_link_if.capture     cap
);

   logic [7:0] timer_prev_q;
   logic [7:0] timer_prev_d;
   logic       pin_prev_q;
   logic       pin_prev_d;
   logic [7:0] port_prev_q;
   logic [7:0] port_prev_d;
   logic [7:0] pin_changed;

   // Per-pin change detect, only on enabled pins
   for (genvar i = 0; i < 8; i++) begin : g_chg
      assign pin_changed[i] = (monitored_port[i] ^ port_prev_q[i]) & per_pin_change_enables[i]; // [R9]
   end

   always_comb begin
      timer_prev_d  = eight_bit_timer_count;
      pin_prev_d    = external_irq_pin;
      port_prev_d   = monitored_port;
      // Wrap from max to zero; the count itself is never touched here
      cap.timer_evt = (timer_prev_q == TIMER_MAX) && (eight_bit_timer_count == TIMER_ZERO); // [R6] [R10]
      cap.ext_evt   = ext_edge_rising ? (external_irq_pin & ~pin_prev_q)
                                      : (~external_irq_pin & pin_prev_q); // [R7]
      cap.port_evt  = |pin_changed; // [R8]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_prev_q <= TIMER_ZERO;
         pin_prev_q   <= 1'b0;
         port_prev_q  <= 8'h00;
      end else begin
         timer_prev_q <= timer_prev_d;
         pin_prev_q   <= pin_prev_d;
         port_prev_q  <= port_prev_d;
      end
   end

endmodule : event_capture

// ---- hw/irq_sequencer.sv ----
// Acceptance and vectoring sequence toward the core, counted in instruction cycles
module irq_sequencer
   import irq_ctrl_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   irq_link_if.seq   seq
);

   seq_state_e          state_q;
   seq_state_e          state_d;
   logic [1:0]          cnt_q;
   logic [1:0]          cnt_d;
   logic                flush_q;
   logic                flush_d;
   logic                load_q;
   logic                load_d;
   logic                pop_q;
   logic                pop_d;
   logic [VECTOR_W-1:0] vec_q;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      flush_d = 1'b0;
      load_d  = 1'b0;
      pop_d   = seq.ret; // [R13]
      case (state_q)
         SEQ_IDLE: begin
            // Request is sampled only at instruction-cycle start
            if (seq.tick && seq.req) begin
               flush_d = 1'b1; // [R12]
               cnt_d   = CNT_ZERO;
               state_d = SEQ_WAIT;
            end
         end
         SEQ_WAIT: begin
            if (seq.tick) begin
               if (cnt_q == LAT_LAST) begin
                  load_d  = 1'b1; // [R14] [R12]
                  state_d = SEQ_IDLE;
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
               end
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SEQ_IDLE;
         cnt_q   <= CNT_ZERO;
         flush_q <= 1'b0;
         load_q  <= 1'b0;
         pop_q   <= 1'b0;
         vec_q   <= IRQ_VECTOR;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         flush_q <= flush_d;
         load_q  <= load_d;
         pop_q   <= pop_d;
         vec_q   <= vec_q;
      end
   end

   assign seq.accept = flush_q;
   assign seq.push   = load_q;
   assign seq.load   = load_q;
   assign seq.pop    = pop_q;
   assign seq.busy   = (state_q == SEQ_WAIT);
   assign seq.vector = vec_q;

endmodule : irq_sequencer

// ---- hw/core_interrupt_control.sv ----
// Core interrupt control: control register, Avalon-MM slave and core request path
//
// Implementation choices: the register offsets and the Avalon-MM register port.
module core_interrupt_control
   import irq_ctrl_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   // Event sources
   input  wire logic [7:0]          eight_bit_timer_count,
   input  wire logic                external_irq_pin,
   input  wire logic                ext_edge_rising,
   input  wire logic [7:0]          monitored_port,
   input  wire logic                periph_req,
   // Core sequencer side
   input  wire logic                instr_tick,
   input  wire logic                return_from_irq_instr,
   output logic                     core_irq_req,
   output logic                     fetch_flush,
   output logic                     pc_push,
   output logic                     pc_pop,
   output logic                     vector_load,
   output logic [VECTOR_W-1:0]      vector_addr,
   output logic                     irq
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]        ctrl_q;
   logic [7:0]        ctrl_d;
   logic [7:0]        pin_en_q;
   logic [7:0]        pin_en_d;
   logic [STAT_W-1:0] stat_q;
   logic [STAT_W-1:0] stat_d;
   logic [STAT_W-1:0] mask_q;
   logic [STAT_W-1:0] mask_d;
   logic              wait_q;
   logic              wait_d;
   logic [31:0]       rdata_q;
   logic [31:0]       rdata_d;
   logic              req_q;
   logic              req_d;
   logic              irq_q;
   logic              irq_d;

   logic              bus_req;
   logic              wr_fire;
   logic              rd_fire;
   logic              lane0;
   logic [7:0]        wbyte;
   logic              req_now;
   logic              timer_pair;
   logic              ext_pair;
   logic              port_pair;
   logic              periph_pair;
   logic [31:0]       rd_mux;

   irq_link_if lnk ();

   event_capture u_capture (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .eight_bit_timer_count  (eight_bit_timer_count),
      .external_irq_pin       (external_irq_pin),
      .ext_edge_rising        (ext_edge_rising),
      .monitored_port         (monitored_port),
      .per_pin_change_enables (pin_en_q),
      .cap                    (lnk)
   );

   irq_sequencer u_seq (
      .clk   (clk),
      .rst_n (rst_n),
      .seq   (lnk)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Request combination
   always_comb begin
      timer_pair  = ctrl_q[BIT_TIMER_EN] & ctrl_q[BIT_TIMER_FLAG]; // [R3]
      ext_pair    = ctrl_q[BIT_PIN_EN] & ctrl_q[BIT_PIN_FLAG];     // [R4]
      port_pair   = ctrl_q[BIT_PORT_EN] & ctrl_q[BIT_PORT_FLAG];   // [R5]
      periph_pair = ctrl_q[BIT_PERIPH_EN] & periph_req;            // [R2]
      req_now     = ctrl_q[BIT_GLOBAL_EN]
                    & (timer_pair | ext_pair | port_pair | periph_pair); // [R1] [R15]
   end

   assign lnk.req  = req_now;
   assign lnk.tick = instr_tick;
   assign lnk.ret  = return_from_irq_instr;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   // One wait cycle per access; the access completes at the edge where waitrequest is low.
   always_comb begin
      bus_req  = avs_read | avs_write;
      wr_fire  = avs_write & ~wait_q;
      rd_fire  = avs_read & ~wait_q;
      lane0    = avs_byteenable[0];
      wbyte    = avs_writedata[7:0];
      wait_d   = ~(bus_req & wait_q);
   end

   // Read data is snapshot one cycle before completion
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_hit(avs_address, OFF_CTRL)) begin
         rd_mux[7:0] = ctrl_q;
      end else if (addr_hit(avs_address, OFF_PIN_EN)) begin
         rd_mux[7:0] = pin_en_q;
      end else if (addr_hit(avs_address, OFF_STATUS)) begin
         rd_mux[STAT_W-1:0] = stat_q;
      end else if (addr_hit(avs_address, OFF_MASK)) begin
         rd_mux[STAT_W-1:0] = mask_q;
      end else if (addr_hit(avs_address, OFF_STATE)) begin
         rd_mux[ST_REQ]    = req_q;
         rd_mux[ST_PERIPH] = periph_req;
         rd_mux[ST_BUSY]   = lnk.busy;
      end
      rdata_d = rdata_q;
      if (avs_read && wait_q) begin
         rdata_d = rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Control register
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_fire && lane0 && addr_hit(avs_address, OFF_CTRL)) begin
         ctrl_d = wbyte;
      end
      // Hardware updates override a same-cycle software write
      if (lnk.accept) begin
         ctrl_d[BIT_GLOBAL_EN] = 1'b0; // [R12]
      end
      if (lnk.pop) begin
         ctrl_d[BIT_GLOBAL_EN] = 1'b1; // [R13]
      end
      // Sets win over software clears so no event is lost
      if (lnk.timer_evt) begin
         ctrl_d[BIT_TIMER_FLAG] = 1'b1; // [R6] [R11]
      end
      if (lnk.ext_evt) begin
         ctrl_d[BIT_PIN_FLAG] = 1'b1; // [R7] [R11]
      end
      if (lnk.port_evt) begin
         ctrl_d[BIT_PORT_FLAG] = 1'b1; // [R8] [R11]
      end
   end

   always_comb begin
      pin_en_d = pin_en_q;
      if (wr_fire && lane0 && addr_hit(avs_address, OFF_PIN_EN)) begin
         pin_en_d = wbyte; // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt line
   always_comb begin
      stat_d = stat_q;
      mask_d = mask_q;
      // Only bits the reader actually saw are cleared
      if (rd_fire && addr_hit(avs_address, OFF_STATUS)) begin
         stat_d = stat_q & ~rdata_q[STAT_W-1:0];
      end
      if (wr_fire && lane0 && addr_hit(avs_address, OFF_MASK)) begin
         mask_d = wbyte[STAT_W-1:0];
      end
      if (lnk.accept) begin
         stat_d[ST_TAKEN] = 1'b1;
      end
      if (lnk.pop) begin
         stat_d[ST_RETURN] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
      req_d = req_now;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= CTRL_RESET;
         pin_en_q <= PIN_EN_RESET;
         stat_q   <= STAT_RESET;
         mask_q   <= MASK_RESET;
         wait_q   <= 1'b1;
         rdata_q  <= 32'h0000_0000;
         req_q    <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         ctrl_q   <= ctrl_d;
         pin_en_q <= pin_en_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         wait_q   <= wait_d;
         rdata_q  <= rdata_d;
         req_q    <= req_d;
         irq_q    <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign core_irq_req    = req_q;
   assign fetch_flush     = lnk.accept;
   assign pc_push         = lnk.push;
   assign vector_load     = lnk.load;
   assign pc_pop          = lnk.pop;
   assign vector_addr     = lnk.vector;
   assign irq             = irq_q;

endmodule : core_interrupt_control

// ---- bench/core_irq_assertions.sv ----
// Port-level checks of the core interrupt control block
module core_irq_assertions
   import irq_ctrl_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire logic                instr_tick,
   input wire logic                return_from_irq_instr,
   input wire logic                core_irq_req,
   input wire logic                fetch_flush,
   input wire logic                pc_push,
   input wire logic                pc_pop,
   input wire logic                vector_load,
   input wire logic [VECTOR_W-1:0] vector_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Ticks seen since acceptance, saturating so a late vector still shows
   logic [2:0] ticks_q;
   logic [2:0] ticks_d;
   always_comb begin
      ticks_d = ticks_q;
      if (fetch_flush) begin
         ticks_d = 3'h0;
      end else if (instr_tick && ticks_q != 3'h7) begin
         ticks_d = ticks_q + 3'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks_q <= 3'h0;
      end else begin
         ticks_q <= ticks_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence taken_s;
      fetch_flush;
   endsequence
   sequence req_gone_s;
      ##[1:4] !core_irq_req;
   endsequence

   vec_const_a: assert property (vector_addr == IRQ_VECTOR)
      else $error("vector address wrong");
   flush_on_tick_a: assert property (taken_s |-> $past(instr_tick))
      else $error("acceptance without tick");
   flush_pulse_a: assert property (taken_s |=> !fetch_flush)
      else $error("flush longer than one cycle");
   req_drop_a: assert property (taken_s |-> req_gone_s)
      else $error("request not dropped after acceptance");
   push_load_a: assert property (vector_load == pc_push)
      else $error("push and vector load apart");
   vec_latency_a: assert property (vector_load |-> ticks_q == 3'h3)
      else $error("vector not three ticks after acceptance");
   pop_after_ret_a: assert property (return_from_irq_instr |=> pc_pop)
      else $error("no pop after return");
   pop_cause_a: assert property (pc_pop |-> $past(return_from_irq_instr))
      else $error("pop without return");
   wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
                                   |=> !avs_waitrequest)
      else $error("bus access not answered");
endmodule : core_irq_assertions

bind core_interrupt_control core_irq_assertions chk_u (
   .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .instr_tick(instr_tick),
   .return_from_irq_instr(return_from_irq_instr), .core_irq_req(core_irq_req),
   .fetch_flush(fetch_flush), .pc_push(pc_push), .pc_pop(pc_pop),
   .vector_load(vector_load), .vector_addr(vector_addr));

// ---- bench/irq_far_side.sv ----
// Far-side model: instruction-cycle ticks and the 8-bit timer
module irq_far_side
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   output logic            instr_tick,
   output logic [7:0]      eight_bit_timer_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q;
   // Four clocks to one instruction cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q    <= 2'h0;
         instr_tick <= 1'b0;
      end else begin
         phase_q    <= phase_q + 2'h1;
         instr_tick <= (phase_q == 2'h3);
      end
   end
   // Count ignores reset, so software must load it itself
   initial eight_bit_timer_count = 8'h00;
   always @(posedge clk) begin
      if (load) begin
         eight_bit_timer_count <= load_val;
      end else if (run) begin
         eight_bit_timer_count <= eight_bit_timer_count + 8'h01;
      end
   end
endmodule : irq_far_side

// ---- bench/core_interrupt_control_tb.sv ----
// Self-checking bench of the core interrupt control block
module core_interrupt_control_tb import irq_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk, rst_n, avs_read, avs_write, avs_waitrequest, load, run;
   logic [ADDR_W-1:0]   avs_address;
   logic [31:0]         avs_writedata, avs_readdata, rdata;
   logic [3:0]          avs_byteenable;
   logic [7:0]          monitored_port, eight_bit_timer_count, load_val, c, v;
   logic                external_irq_pin, periph_req, instr_tick, return_from_irq_instr, p;
   logic                core_irq_req, fetch_flush, pc_push, pc_pop, vector_load, irq;
   logic [VECTOR_W-1:0] vector_addr;
   logic                ext_edge_rising;
   logic [7:0]          rows [9] = '{8'h40, 8'hC0, 8'h80, 8'hA4, 8'h84, 8'h92, 8'h82,
                                     8'h89, 8'h81};
   int                  failures, total_checks, n;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   core_interrupt_control dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .eight_bit_timer_count(eight_bit_timer_count),
      .external_irq_pin(external_irq_pin), .ext_edge_rising(ext_edge_rising),
      .monitored_port(monitored_port), .periph_req(periph_req), .instr_tick(instr_tick),
      .return_from_irq_instr(return_from_irq_instr), .core_irq_req(core_irq_req),
      .fetch_flush(fetch_flush), .pc_push(pc_push), .pc_pop(pc_pop),
      .vector_load(vector_load), .vector_addr(vector_addr), .irq(irq));
   irq_far_side far_u (.clk(clk), .rst_n(rst_n), .run(run), .load(load),
      .load_val(load_val), .instr_tick(instr_tick),
      .eight_bit_timer_count(eight_bit_timer_count));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic req_exp(input logic [7:0] r, input logic pr);
      req_exp = r[7] & ((r[5] & r[2]) | (r[4] & r[1]) | (r[3] & r[0]) | (r[6] & pr));
   endfunction : req_exp
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   // Request held until waitrequest is seen low
   task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= {24'h0, d};
      avs_read      <= !we;
      avs_write     <= we;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) failures++;
      rdata = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(what, exp, rdata);
   endtask : rd
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #200us;
      failures++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, avs_read, avs_write, load, run, external_irq_pin, periph_req} = '0;
      {return_from_irq_instr, avs_address, avs_writedata, monitored_port, load_val} = '0;
      avs_byteenable = 4'hF;
      ext_edge_rising = 1'b1;
      void'($urandom(45));
      cyc(12);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) rd("reset value", 5'(4 * i), 32'h0);
      bus(1'b1, 5'h14, 8'hFF);
      rd("unmapped", 5'h14, 32'h0);
      avs_byteenable <= 4'hE;
      bus(1'b1, OFF_CTRL, 8'h7F);
      avs_byteenable <= 4'hF;
      rd("byte gated", OFF_CTRL, 32'h0);
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom) & 8'h7F;
         bus(1'b1, OFF_CTRL, v);
         rd("control", OFF_CTRL, {24'h0, v});
         bus(1'b1, OFF_PIN_EN, ~v);
         rd("pin enables", OFF_PIN_EN, {24'h0, ~v});
      end
      bus(1'b1, OFF_CTRL, 8'h00);
      bus(1'b1, OFF_PIN_EN, 8'h01);
      load     <= 1'b1;
      load_val <= 8'hFE;
      cyc(1);
      load <= 1'b0;
      run  <= 1'b1;
      cyc(4);
      run <= 1'b0;
      rd("timer flag", OFF_CTRL, 32'h04);
      bus(1'b1, OFF_CTRL, 8'h00);
      external_irq_pin <= 1'b1;
      cyc(3);
      rd("pin flag", OFF_CTRL, 32'h02);
      bus(1'b1, OFF_CTRL, 8'h00);
      external_irq_pin <= 1'b0;
      cyc(3);
      rd("falling edge", OFF_CTRL, 32'h00);
      // Falling-edge mode, switched while pin and its sample agree
      ext_edge_rising  <= 1'b0;
      external_irq_pin <= 1'b1;
      cyc(3);
      rd("rise ignored", OFF_CTRL, 32'h00);
      external_irq_pin <= 1'b0;
      cyc(3);
      rd("falling flag", OFF_CTRL, 32'h02);
      bus(1'b1, OFF_CTRL, 8'h00);
      ext_edge_rising  <= 1'b1;
      monitored_port <= 8'h80;
      cyc(3);
      rd("masked pin", OFF_CTRL, 32'h00);
      monitored_port <= 8'h81;
      cyc(3);
      rd("port flag", OFF_CTRL, 32'h01);
      bus(1'b1, OFF_CTRL, 8'h00);
      $display("events done");
      for (int i = 0; i < 15; i++) begin
         c = (i < 9) ? rows[i] : 8'($urandom);
         p = (i < 9) ? 1'b1 : 1'($urandom);
         periph_req <= p;
         bus(1'b1, OFF_CTRL, c);
         n = 0;
         while (fetch_flush !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
         end
         chk("acceptance", 32'(req_exp(c, p)), 32'(n < 40));
         chk("core request", 32'(req_exp(c, p)), 32'(core_irq_req));
         if (n < 40) begin
            // Far model gives one tick every four clocks
            n = 0;
            while (vector_load !== 1'b1 && n < 40) begin
               @(posedge clk);
               n++;
            end
            chk("vector latency", 32'(IRQ_LATENCY_TCY) * 32'd4, 32'(n));
            chk("vector push", 32'h1, 32'(pc_push));
            chk("vector address", 32'(IRQ_VECTOR), 32'(vector_addr));
            chk("request dropped", 32'h0, 32'(core_irq_req));
            cyc(3);
            rd("global cleared", OFF_CTRL, {24'h0, c & 8'h7F});
            bus(1'b1, OFF_CTRL, 8'h00);
            periph_req <= 1'b0;
            cyc(20);
            return_from_irq_instr <= 1'b1;
            cyc(1);
            return_from_irq_instr <= 1'b0;
            cyc(3);
            rd("global restored", OFF_CTRL, 32'h80);
         end
         bus(1'b1, OFF_CTRL, 8'h00);
         cyc(20);
      end
      $display("request gating done");
      bus(1'b1, OFF_MASK, 8'h00);
      cyc(2);
      chk("masked irq", 32'h0, 32'(irq));
      bus(1'b1, OFF_MASK, 8'h03);
      cyc(2);
      chk("irq raised", 32'h1, 32'(irq));
      rd("status", OFF_STATUS, 32'h03);
      cyc(2);
      chk("irq cleared", 32'h0, 32'(irq));
      rd("status cleared", OFF_STATUS, 32'h00);
      $display("interrupt done");
      end_of_test();
   end
endmodule : core_interrupt_control_tb
